// ==== verilog/xfer_rec_pkg.sv ====
// Purpose: shared constants and types of the transfer history recorder
// Assumes: privilege codes 0 user, 1 supervisor, 3 machine
// Notes: bit positions index the 64-bit control register
package xfer_rec_pkg;
  localparam int CTL_W = 64;
  localparam int B_U = 0;
  localparam int B_S = 1;
  localparam int B_M = 2;
  localparam int B_RAS = 7;
  localparam int B_STE = 8;
  localparam int B_MTE = 9;
  localparam int B_BPH = 11;
  localparam int B_OVH = 12;
  localparam int B_EXC = 33;
  localparam int B_INT = 34;
  localparam int B_TRET = 35;
  localparam int B_NTB = 36;
  localparam int B_TKB = 37;
  localparam int B_CLS = 40;
  localparam int B_CUST = 60;
  localparam int DEPTH_BASE_LOG2 = 4;
  localparam logic [63:0] CTL_RESET = 64'h0;
  localparam logic [2:0] DEPTH_RESET = 3'h0;
  localparam logic [1:0] PRIV_U = 2'h0;
  localparam logic [1:0] PRIV_S = 2'h1;
  localparam logic [1:0] PRIV_M = 2'h3;
  // class kinds from xf_indcall upward follow the suppress bits from B_CLS
  typedef enum logic [3:0] {XF_EXC, XF_INTR, XF_TRET, XF_NTBR, XF_TKBR, XF_INDCALL, XF_DIRCALL,
    XF_INDJMP, XF_DIRJMP, XF_CORSWAP, XF_RET, XF_INDLJMP, XF_DIRLJMP} xfer_kind_t;
  function automatic logic mode_on(input logic [63:0] ctl, input logic [1:0] priv);
    mode_on = (priv == PRIV_M) ? ctl[B_M] : (priv == PRIV_S) ? ctl[B_S] : (priv == PRIV_U) ? ctl[B_U] : 1'b0;
  endfunction
endpackage

// ==== verilog/xfer_store.sv ====
// Purpose: record memory, one write port, registered read port
// Assumes: array content is undefined after reset
// Notes: read data follow the address by one clock
`timescale 1ns/1ps
module xfer_store #(
  parameter int W = 132,
  parameter int DEPTH = 128,
  parameter int AW = 7
) (
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  input wire logic we_in,
  input wire logic [AW-1:0] waddr_in,
  input wire logic [W-1:0] wdata_in,
  input wire logic [AW-1:0] raddr_in,
  output logic [W-1:0] rdata_out
);
  typedef struct packed {logic [W-1:0] rdata;} store_state_t;
  store_state_t s_q, s_d;
  logic [W-1:0] mem [DEPTH];
  always_comb begin
    s_d.rdata = mem[raddr_in];
  end
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  always_ff @(posedge clk_sys_in) begin
    if (we_in) begin
      mem[waddr_in] <= wdata_in;
    end
  end
  assign rdata_out = s_q.rdata;
endmodule

// ==== verilog/xfer_filter.sv ====
// Purpose: privilege and transfer-type qualification of one retired transfer
// Assumes: control word already legalised
// Notes: purely combinational
`timescale 1ns/1ps
module xfer_filter
  import xfer_rec_pkg::*;
(
  input wire logic [63:0] ctl_in,
  input wire xfer_kind_t kind_in,
  input wire logic [1:0] priv_in,
  input wire logic [1:0] trap_priv_in,
  output logic mode_pass_out,
  output logic type_pass_out
);
  logic is_trap;
  logic [3:0] cls;
  always_comb begin
    is_trap = (kind_in == XF_EXC) || (kind_in == XF_INTR);
    cls = 4'(kind_in - XF_INDCALL);
    // traps may pass on the target's trap enable alone
    mode_pass_out = mode_on(ctl_in, priv_in) || (is_trap && ((trap_priv_in == PRIV_M && ctl_in[B_MTE]) ||
      (trap_priv_in == PRIV_S && ctl_in[B_STE])));
    case (kind_in)
      XF_EXC: type_pass_out = !ctl_in[B_EXC];
      XF_INTR: type_pass_out = !ctl_in[B_INT];
      XF_TRET: type_pass_out = !ctl_in[B_TRET];
      XF_NTBR: type_pass_out = ctl_in[B_NTB];
      XF_TKBR: type_pass_out = !ctl_in[B_TKB];
      XF_INDCALL, XF_DIRCALL, XF_INDJMP, XF_DIRJMP, XF_CORSWAP, XF_RET, XF_INDLJMP,
      XF_DIRLJMP: type_pass_out = !ctl_in[B_CLS + int'(cls)];
      default: type_pass_out = 1'b0;
    endcase
  end
endmodule

// ==== verilog/transfer_history_recorder.sv ====
// Purpose: records qualified control transfers into a circular record buffer
// Assumes: retirement side presents at most one transfer per clock
// Notes: entries are reached by logical index, 0 being the youngest
`timescale 1ns/1ps
module transfer_history_recorder
  import xfer_rec_pkg::*;
#(
  parameter int PC_W = 64,
  parameter int MAX_DEPTH = 128,
  parameter bit HAS_OVF_FILTER = 1'b1,
  parameter bit NARROW_BASE = 1'b0,
  parameter bit CUSTOM_EN = 1'b0
) (
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  input wire logic ret_valid_in,
  input wire xfer_kind_t ret_kind_in,
  input wire logic [1:0] ret_priv_in,
  input wire logic [1:0] ret_trap_priv_in,
  input wire logic ret_breakpoint_in,
  input wire logic ret_local_counter_overflow_irq_in,
  input wire logic [PC_W-1:0] ret_src_pc_in,
  input wire logic [PC_W-1:0] ret_tgt_pc_in,
  input wire logic ctl_we_in,
  input wire logic [63:0] ctl_wdata_in,
  output logic [63:0] ctl_rdata_out,
  input wire logic depth_we_in,
  input wire logic [2:0] depth_wdata_in,
  output logic [2:0] depth_rdata_out,
  input wire logic entry_sel_we_in,
  input wire logic [7:0] entry_sel_in,
  input wire logic entry_we_in,
  input wire logic [PC_W-1:0] entry_src_in,
  input wire logic [PC_W-1:0] entry_tgt_in,
  input wire logic [3:0] entry_kind_in,
  output logic [PC_W-1:0] entry_src_out,
  output logic [PC_W-1:0] entry_tgt_out,
  output logic [3:0] entry_kind_out,
  input wire logic halt_clear_in,
  output logic recorder_halted_flag_out,
  output logic [$clog2(MAX_DEPTH)-1:0] write_ptr_out
);
  localparam int AW = $clog2(MAX_DEPTH);
  localparam int RW = 2 * PC_W + 4;
  localparam logic [2:0] DEPTH_MAX_CODE = 3'(AW - DEPTH_BASE_LOG2);

  // depth code to pointer mask, 16 << code records
  function automatic logic [AW-1:0] depth_mask(input logic [2:0] code);
    depth_mask = AW'((1 << (DEPTH_BASE_LOG2 + int'(code))) - 1);
  endfunction

  // writable control fields; everything else reads as zero
  function automatic logic [63:0] ctl_field_mask(input bit ovf, input bit cust);
    logic [63:0] m;
    m = 64'h0;
    m[B_U] = 1'b1;
    m[B_S] = 1'b1;
    m[B_M] = 1'b1;
    m[B_RAS] = 1'b1;
    m[B_STE] = 1'b1;
    m[B_MTE] = 1'b1;
    m[B_BPH] = 1'b1;
    m[B_OVH] = ovf;
    for (int i = 0; i < 5; i++) begin
      m[B_EXC + i] = 1'b1;
    end
    for (int i = 0; i < 8; i++) begin
      m[B_CLS + i] = 1'b1;
    end
    for (int i = 0; i < 4; i++) begin
      m[B_CUST + i] = cust;
    end
    ctl_field_mask = m;
  endfunction

  localparam logic [63:0] CTL_BASE_MASK = ctl_field_mask(HAS_OVF_FILTER, CUSTOM_EN);
  localparam logic [63:0] CTL_MASK = NARROW_BASE ? (CTL_BASE_MASK & 64'h0000_0000_ffff_ffff) : CTL_BASE_MASK;

  typedef struct packed {
    logic [63:0] ctl;
    logic [2:0] depth;
    logic [AW-1:0] wptr;
    logic [7:0] sel;
    logic halted;
  } rec_state_t;
  rec_state_t s_q, s_d;

  logic mode_pass;
  logic type_pass;
  logic is_call;
  logic is_ret;
  logic freeze_now;
  logic do_rec;
  logic do_pop;
  logic sw_wr;
  logic [AW-1:0] mask;
  logic [AW-1:0] ent_addr;
  logic mem_we;
  logic [AW-1:0] mem_waddr;
  logic [RW-1:0] mem_wdata;
  logic [RW-1:0] mem_rdata;

  xfer_filter u_filter (
    .ctl_in(s_q.ctl),
    .kind_in(ret_kind_in),
    .priv_in(ret_priv_in),
    .trap_priv_in(ret_trap_priv_in),
    .mode_pass_out(mode_pass),
    .type_pass_out(type_pass)
  );

  always_comb begin
    mask = depth_mask(s_q.depth);
    is_call = (ret_kind_in == XF_INDCALL) || (ret_kind_in == XF_DIRCALL);
    is_ret = (ret_kind_in == XF_RET);
    // a freezing trap is itself not recorded
    freeze_now = ret_valid_in && (ret_trap_priv_in == PRIV_M || ret_trap_priv_in == PRIV_S) &&
      (ret_kind_in == XF_EXC || ret_kind_in == XF_INTR) &&
      ((ret_breakpoint_in && s_q.ctl[B_BPH]) ||
      (ret_local_counter_overflow_irq_in && ret_kind_in == XF_INTR && s_q.ctl[B_OVH]));
    do_rec = ret_valid_in && !s_q.halted && !freeze_now && mode_pass &&
      (s_q.ctl[B_RAS] ? is_call : type_pass);
    do_pop = ret_valid_in && !s_q.halted && !freeze_now && mode_pass && s_q.ctl[B_RAS] && is_ret;
    // logical index counts back from the youngest entry
    ent_addr = (s_q.wptr - AW'(1) - s_q.sel[AW-1:0]) & mask;
    sw_wr = entry_we_in && !do_rec;
    mem_we = do_rec || sw_wr;
    mem_waddr = do_rec ? s_q.wptr : ent_addr;
    mem_wdata = do_rec ? {ret_src_pc_in, ret_tgt_pc_in, 4'(ret_kind_in)} :
      {entry_src_in, entry_tgt_in, entry_kind_in};
  end

  always_comb begin
    s_d = s_q;
    if (ctl_we_in) begin
      s_d.ctl = (s_q.ctl & ~CTL_MASK) | (ctl_wdata_in & CTL_MASK);
    end
    if (depth_we_in) begin
      s_d.depth = (depth_wdata_in > DEPTH_MAX_CODE) ? DEPTH_MAX_CODE : depth_wdata_in;
    end
    if (entry_sel_we_in) begin
      s_d.sel = entry_sel_in;
    end
    if (do_rec) begin
      s_d.wptr = (s_q.wptr + AW'(1)) & mask;
    end else if (do_pop) begin
      s_d.wptr = (s_q.wptr - AW'(1)) & mask;
    end else if (depth_we_in) begin
      s_d.wptr = s_q.wptr & depth_mask(s_d.depth);
    end
    // setting wins over a clear in the same cycle
    if (freeze_now) begin
      s_d.halted = 1'b1;
    end else if (halt_clear_in) begin
      s_d.halted = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s_q <= '{ctl: CTL_RESET, depth: DEPTH_RESET, wptr: '0, sel: '0, halted: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  xfer_store #(.W(RW), .DEPTH(MAX_DEPTH), .AW(AW)) u_store (
    .clk_sys_in(clk_sys_in),
    .rst_b_in(rst_b_in),
    .we_in(mem_we),
    .waddr_in(mem_waddr),
    .wdata_in(mem_wdata),
    .raddr_in(ent_addr),
    .rdata_out(mem_rdata)
  );

  assign ctl_rdata_out = s_q.ctl;
  assign depth_rdata_out = s_q.depth;
  assign recorder_halted_flag_out = s_q.halted;
  assign write_ptr_out = s_q.wptr;
  assign entry_src_out = mem_rdata[RW-1 -: PC_W];
  assign entry_tgt_out = mem_rdata[PC_W+3 -: PC_W];
  assign entry_kind_out = mem_rdata[3:0];

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_b_in);

  AST_PTR_ADV: assert property (do_rec |=> s_q.wptr == (($past(s_q.wptr) + AW'(1)) & $past(mask)))
    else $error("write pointer did not advance on a record");
  AST_RAS_POP: assert property (do_pop |=> s_q.wptr == (($past(s_q.wptr) - AW'(1)) & $past(mask)))
    else $error("write pointer did not step back on a return");
  AST_RAS_NO_RET: assert property (s_q.ctl[B_RAS] && ret_valid_in && is_ret |-> !do_rec)
    else $error("return recorded in stack emulation");
  AST_HALT_HOLD: assert property (s_q.halted && !depth_we_in |=> $stable(s_q.wptr))
    else $error("write pointer moved while halted");
  AST_BP_FREEZE: assert property (ret_valid_in && ret_breakpoint_in && ret_kind_in == XF_EXC &&
    ret_trap_priv_in == PRIV_M && s_q.ctl[B_BPH] |=> recorder_halted_flag_out [*2])
    else $error("breakpoint trap did not halt the recorder");
  AST_OVF_FREEZE: assert property (ret_valid_in && ret_local_counter_overflow_irq_in && ret_kind_in == XF_INTR &&
    ret_trap_priv_in == PRIV_S && s_q.ctl[B_OVH] |=> recorder_halted_flag_out)
    else $error("overflow interrupt did not halt the recorder");
  AST_DEPTH_LEGAL: assert property (s_q.depth <= DEPTH_MAX_CODE)
    else $error("illegal depth code held");
  AST_CTL_ZERO: assert property ((s_q.ctl & ~CTL_MASK) == 64'h0)
    else $error("unimplemented control bit reads nonzero");
  AST_MODE_FILTER: assert property (ret_valid_in && !mode_on(s_q.ctl, ret_priv_in) &&
    ret_kind_in != XF_EXC && ret_kind_in != XF_INTR |-> !do_rec)
    else $error("transfer from disabled mode recorded");
  AST_YOUNGEST: assert property (do_rec && s_q.sel == 8'h0 && !entry_sel_we_in && !depth_we_in
    |=> ##2 entry_src_out == $past(ret_src_pc_in, 3))
    else $error("index zero is not the youngest record");

  // type filter: suppress and enable bits
  AST_EXC_OFF: assert property (ret_valid_in && ret_kind_in == XF_EXC && s_q.ctl[B_EXC] &&
    !s_q.ctl[B_RAS] |-> !do_rec)
    else $error("exception recorded while suppressed");
  AST_INT_OFF: assert property (ret_valid_in && ret_kind_in == XF_INTR && s_q.ctl[B_INT] &&
    !s_q.ctl[B_RAS] |-> !do_rec)
    else $error("interrupt recorded while suppressed");
  AST_TRET_OFF: assert property (ret_valid_in && ret_kind_in == XF_TRET && s_q.ctl[B_TRET] &&
    !s_q.ctl[B_RAS] |-> !do_rec)
    else $error("trap return recorded while suppressed");
  AST_NTB_OFF: assert property (ret_valid_in && ret_kind_in == XF_NTBR && !s_q.ctl[B_NTB] &&
    !s_q.ctl[B_RAS] |-> !do_rec)
    else $error("untaken branch recorded while not enabled");
  AST_TKB_OFF: assert property (ret_valid_in && ret_kind_in == XF_TKBR && s_q.ctl[B_TKB] &&
    !s_q.ctl[B_RAS] |-> !do_rec)
    else $error("taken branch recorded while suppressed");
  AST_NTB_ON: assert property (ret_valid_in && ret_kind_in == XF_NTBR && s_q.ctl[B_NTB] &&
    ret_priv_in == PRIV_M && s_q.ctl[B_M] && !s_q.ctl[B_RAS] && !s_q.halted && !freeze_now
    |-> do_rec)
    else $error("enabled untaken branch not recorded");
  AST_MODE_U: assert property (ret_valid_in && ret_kind_in == XF_TKBR && !s_q.ctl[B_TKB] &&
    ret_priv_in == PRIV_U && s_q.ctl[B_U] && !s_q.ctl[B_RAS] && !s_q.halted && !freeze_now
    |-> do_rec)
    else $error("taken branch in enabled user mode not recorded");

  // each class suppress bit, one check per bit
  for (genvar g = 0; g < 8; g++) begin : g_cls_off
    AST_CLS_OFF: assert property (ret_valid_in && int'(ret_kind_in) == int'(XF_INDCALL) + g &&
      s_q.ctl[B_CLS + g] && !s_q.ctl[B_RAS] |-> !do_rec)
      else $error("suppressed jump or call class recorded");
  end

  // privilege and trap enables
  AST_TRAP_M: assert property (ret_valid_in && ret_kind_in == XF_EXC && ret_trap_priv_in == PRIV_M &&
    s_q.ctl[B_MTE] && !s_q.ctl[B_EXC] && !s_q.ctl[B_RAS] && !s_q.halted && !freeze_now
    |-> do_rec)
    else $error("trap into machine mode not recorded");
  AST_TRAP_S: assert property (ret_valid_in && ret_kind_in == XF_INTR && ret_trap_priv_in == PRIV_S &&
    s_q.ctl[B_STE] && !s_q.ctl[B_INT] && !s_q.ctl[B_RAS] && !s_q.halted && !freeze_now
    |-> do_rec)
    else $error("trap into supervisor mode not recorded");
  AST_NO_REC_IDLE: assert property (!ret_valid_in |-> !do_rec && !do_pop)
    else $error("pointer action without a retired transfer");

  // stack emulation
  AST_RAS_CALL_ONLY: assert property (s_q.ctl[B_RAS] && ret_kind_in != XF_INDCALL &&
    ret_kind_in != XF_DIRCALL |-> !do_rec)
    else $error("non-call recorded in stack emulation");
  AST_RAS_POP_EN: assert property (ret_valid_in && s_q.ctl[B_RAS] && ret_kind_in == XF_RET &&
    mode_on(s_q.ctl, ret_priv_in) && !s_q.halted |-> do_pop)
    else $error("return did not remove the last call");

  // pointer and storage
  AST_REC_SLOT: assert property (do_rec |-> mem_we && mem_waddr == s_q.wptr)
    else $error("record not written at the write pointer");
  AST_REC_DATA: assert property (do_rec |-> mem_wdata[RW-1 -: PC_W] == ret_src_pc_in &&
    mem_wdata[PC_W+3 -: PC_W] == ret_tgt_pc_in && mem_wdata[3:0] == 4'(ret_kind_in))
    else $error("record content differs from the transfer");
  AST_SW_WRITE: assert property (entry_we_in && !do_rec |-> mem_we && mem_waddr == ent_addr)
    else $error("software entry write missed the selected entry");
  AST_SW_DROP: assert property (do_rec && entry_we_in |-> mem_waddr == s_q.wptr)
    else $error("software write displaced a record");
  AST_PTR_IDLE: assert property (!do_rec && !do_pop && !depth_we_in |=> $stable(s_q.wptr))
    else $error("write pointer moved without a record");

  // halt
  AST_HALT_NO_REC: assert property (s_q.halted |-> !do_rec && !do_pop)
    else $error("recorder changed history while halted");
  AST_FREEZE_NOREC: assert property (freeze_now |-> !do_rec)
    else $error("halting trap was recorded");
  AST_SET_WINS: assert property (freeze_now && halt_clear_in |=> recorder_halted_flag_out)
    else $error("halt clear beat a halting trap");
  AST_CLEAR: assert property (!freeze_now && halt_clear_in |=> !recorder_halted_flag_out)
    else $error("halt clear ignored");
  AST_HALT_ONLY: assert property (!freeze_now && !s_q.halted |=> !recorder_halted_flag_out)
    else $error("recorder halted without a trigger");
  AST_BP_S: assert property (ret_valid_in && ret_breakpoint_in && ret_kind_in == XF_EXC &&
    ret_trap_priv_in == PRIV_S && s_q.ctl[B_BPH] |=> recorder_halted_flag_out)
    else $error("breakpoint into supervisor mode did not halt");
  AST_NO_FREEZE_OFF: assert property (!s_q.ctl[B_BPH] && !s_q.ctl[B_OVH] |-> !freeze_now)
    else $error("halt triggered with halt enables clear");
  AST_OVF_KIND: assert property (ret_kind_in != XF_INTR && !ret_breakpoint_in
    |-> !freeze_now)
    else $error("overflow halt on a non-interrupt");

  // registers
  AST_SEL_SET: assert property (entry_sel_we_in |=> s_q.sel == $past(entry_sel_in))
    else $error("entry select not taken");
  AST_SEL_IDLE: assert property (!entry_sel_we_in |=> $stable(s_q.sel))
    else $error("entry select changed without a write");
  AST_CTL_WRITE: assert property (ctl_we_in |=> ctl_rdata_out == ($past(ctl_wdata_in) & CTL_MASK))
    else $error("control write not taken");
  AST_CTL_IDLE: assert property (!ctl_we_in |=> $stable(ctl_rdata_out))
    else $error("control changed without a write");
  AST_DEPTH_WRITE: assert property (depth_we_in && depth_wdata_in <= DEPTH_MAX_CODE
    |=> depth_rdata_out == $past(depth_wdata_in))
    else $error("legal depth code not taken");
  AST_DEPTH_CLAMP: assert property (depth_we_in && depth_wdata_in > DEPTH_MAX_CODE
    |=> depth_rdata_out == DEPTH_MAX_CODE)
    else $error("oversized depth code not clamped");
  AST_DEPTH_IDLE: assert property (!depth_we_in |=> $stable(depth_rdata_out))
    else $error("depth changed without a write");

  COV_REC: cover property (do_rec);
  COV_POP: cover property (do_pop);
  COV_WRAP: cover property (do_rec && s_q.wptr == mask);
  COV_HALT: cover property (freeze_now ##1 halt_clear_in);
  COV_RAS_CALL: cover property (do_rec && s_q.ctl[B_RAS]);
endmodule

// ==== dv/xfer_retire_model.sv ====
// Purpose: retirement side model presenting one retired transfer at a time
// Assumes: called from the bench, changes lines at the falling clock edge
// Notes: pc lines carry inverted values between transfers so stale data never match
`timescale 1ns/1ps
module xfer_retire_model
  import xfer_rec_pkg::*;
(
  input wire logic clk_sys_in,
  output logic ret_valid_out,
  output xfer_kind_t ret_kind_out,
  output logic [1:0] ret_priv_out,
  output logic [1:0] ret_trap_priv_out,
  output logic ret_breakpoint_out,
  output logic ret_ovf_irq_out,
  output logic [63:0] ret_src_pc_out,
  output logic [63:0] ret_tgt_pc_out
);
  initial begin
    {ret_valid_out, ret_priv_out, ret_trap_priv_out, ret_breakpoint_out, ret_ovf_irq_out} = '0;
    ret_kind_out = XF_EXC;
    ret_src_pc_out = '0;
    ret_tgt_pc_out = '0;
  end
  task automatic send(input xfer_kind_t k, input logic [1:0] p, input logic [1:0] tp, input logic bp,
    input logic ov, input logic [63:0] s, input logic [63:0] t);
    @(negedge clk_sys_in);
    {ret_valid_out, ret_priv_out, ret_trap_priv_out, ret_breakpoint_out, ret_ovf_irq_out} = {1'b1, p, tp, bp, ov};
    ret_kind_out = k;
    ret_src_pc_out = s;
    ret_tgt_pc_out = t;
    // one-cycle pulse per transfer
    @(negedge clk_sys_in);
    ret_valid_out = 1'b0;
    ret_src_pc_out = ~s;
    ret_tgt_pc_out = ~t;
  endtask
endmodule

// ==== dv/transfer_history_recorder_tb.sv ====
// Purpose: self-checking bench of the transfer history recorder
// Assumes: default parameters, depth code 0 while recording (16 records)
// Notes: expectations come from a reference filter and a history queue
`timescale 1ns/1ps
module transfer_history_recorder_tb
  import xfer_rec_pkg::*;
;
  localparam logic [63:0] CMASK = 64'h0000_ff3e_0000_1b87;
  logic clk_sys_in = 1'b0;
  logic rst_b_in = 1'b0;
  xfer_kind_t ret_kind_in;
  logic [1:0] ret_priv_in, ret_trap_priv_in;
  logic [63:0] ret_src_pc_in, ret_tgt_pc_in, ctl_wdata_in, ctl_rdata_out, entry_src_in, entry_tgt_in;
  logic [63:0] entry_src_out, entry_tgt_out, ctl_m;
  logic ret_valid_in, ret_breakpoint_in, ret_local_counter_overflow_irq_in, halt_m;
  logic ctl_we_in, depth_we_in, entry_sel_we_in, entry_we_in, halt_clear_in, recorder_halted_flag_out;
  logic [2:0] depth_wdata_in, depth_rdata_out;
  logic [7:0] entry_sel_in;
  logic [3:0] entry_kind_in, entry_kind_out;
  logic [6:0] write_ptr_out;
  logic [63:0] hs[$], ht[$];
  logic [3:0] hk[$];
  logic [1:0] pv [3] = '{2'h0, 2'h1, 2'h3};
  int bad_count = 0, checked = 0, cycles = 0, wptr_m = 0;
  always #2.5 clk_sys_in = ~clk_sys_in;
  xfer_retire_model model_u (.clk_sys_in(clk_sys_in), .ret_valid_out(ret_valid_in), .ret_kind_out(ret_kind_in),
    .ret_priv_out(ret_priv_in), .ret_trap_priv_out(ret_trap_priv_in), .ret_breakpoint_out(ret_breakpoint_in),
    .ret_ovf_irq_out(ret_local_counter_overflow_irq_in), .ret_src_pc_out(ret_src_pc_in),
    .ret_tgt_pc_out(ret_tgt_pc_in));
  transfer_history_recorder dut_u (.clk_sys_in, .rst_b_in, .ret_valid_in, .ret_kind_in, .ret_priv_in,
    .ret_trap_priv_in, .ret_breakpoint_in, .ret_local_counter_overflow_irq_in, .ret_src_pc_in, .ret_tgt_pc_in,
    .ctl_we_in, .ctl_wdata_in, .ctl_rdata_out, .depth_we_in, .depth_wdata_in, .depth_rdata_out,
    .entry_sel_we_in, .entry_sel_in, .entry_we_in, .entry_src_in, .entry_tgt_in, .entry_kind_in,
    .entry_src_out, .entry_tgt_out, .entry_kind_out, .halt_clear_in, .recorder_halted_flag_out, .write_ptr_out);
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // 0 control, 1 depth, 2 select, 3 halt clear, else entry write
  task automatic reg_wr(input int sel, input logic [63:0] v);
    @(negedge clk_sys_in);
    case (sel)
      0: begin
        {ctl_we_in, ctl_wdata_in, ctl_m} = {1'b1, v, v & CMASK};
      end
      1: {depth_we_in, depth_wdata_in} = {1'b1, v[2:0]};
      2: {entry_sel_we_in, entry_sel_in} = {1'b1, v[7:0]};
      3: {halt_clear_in, halt_m} = 2'b10;
      default: {entry_we_in, entry_src_in, entry_tgt_in, entry_kind_in} = {1'b1, v, ~v, 4'h6};
    endcase
    @(negedge clk_sys_in);
    {ctl_we_in, depth_we_in, entry_sel_we_in, entry_we_in, halt_clear_in} = '0;
  endtask
  task automatic step(input xfer_kind_t k, input logic [1:0] p, input logic [1:0] tp, input logic bp,
    input logic ov);
    logic [63:0] s, t;
    logic frz, ok;
    logic [12:0] tok;
    s = {$urandom, $urandom};
    t = {$urandom, $urandom};
    tok = {~ctl_m[47:40], ~ctl_m[37], ctl_m[36], ~ctl_m[35:33]};
    ok = (p == 2'h3) ? ctl_m[2] : ctl_m[p];
    ok = ok | ((k inside {XF_EXC, XF_INTR}) && ((tp == 2'h3 && ctl_m[9]) || (tp == 2'h1 && ctl_m[8])));
    frz = !halt_m && ((bp && ctl_m[11] && k inside {XF_EXC, XF_INTR}) || (ov && ctl_m[12] && k == XF_INTR));
    ok = ok && !halt_m && !frz;
    model_u.send(k, p, tp, bp, ov, s, t);
    if (ok && (ctl_m[7] ? k inside {XF_INDCALL, XF_DIRCALL} : tok[k])) begin
      wptr_m = (wptr_m + 1) % 16;
      hs.push_front(s);
      ht.push_front(t);
      hk.push_front(4'(k));
    end else if (ok && ctl_m[7] && k == XF_RET) begin
      wptr_m = (wptr_m + 15) % 16;
      hs.delete(0);
      ht.delete(0);
      hk.delete(0);
    end
    halt_m = halt_m | frz;
    check("write pointer", write_ptr_out, 64'(wptr_m));
    check("halted flag", recorder_halted_flag_out, 64'(halt_m));
    @(negedge clk_sys_in);
    check("source pc", entry_src_out, hs[0]);
    check("target pc", entry_tgt_out, ht[0]);
    check("kind", entry_kind_out, 64'(hk[0]));
  endtask
  always @(posedge clk_sys_in) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      end_sim();
    end
  end
  initial begin
    {ctl_we_in, depth_we_in, entry_sel_we_in, entry_we_in, halt_clear_in, halt_m} = '0;
    {ctl_wdata_in, entry_src_in, entry_tgt_in, entry_kind_in, depth_wdata_in, entry_sel_in, ctl_m} = '0;
    void'($urandom(32'h2986e157));
    repeat (5) @(negedge clk_sys_in);
    rst_b_in = 1'b1;
    check("control reset", ctl_rdata_out, 64'h0);
    check("depth reset", depth_rdata_out, 64'h0);
    check("pointer reset", write_ptr_out, 64'h0);
    reg_wr(0, '1);
    check("control fields", ctl_rdata_out, CMASK);
    for (int i = 0; i < 8; i++) begin
      reg_wr(1, 64'(i));
      check("depth code", depth_rdata_out, (i > 3) ? 64'h3 : 64'(i));
    end
    reg_wr(1, 64'h0);
    reg_wr(4, 64'h0123_4567_89ab_cdef);
    @(negedge clk_sys_in);
    check("entry write", entry_src_out, 64'h0123_4567_89ab_cdef);
    hs.push_front(64'h0123_4567_89ab_cdef);
    ht.push_front(~64'h0123_4567_89ab_cdef);
    hk.push_front(4'h6);
    reg_wr(0, 64'h1);
    step(XF_TKBR, 2'h0, 2'h3, 1'b0, 1'b0);
    reg_wr(2, 64'h1);
    @(negedge clk_sys_in);
    check("older entry", entry_src_out, hs[1]);
    reg_wr(2, 64'h0);
    reg_wr(0, 64'h300);
    step(XF_EXC, 2'h3, 2'h3, 1'b0, 1'b0);
    step(XF_INTR, 2'h0, 2'h1, 1'b0, 1'b0);
    step(XF_TKBR, 2'h1, 2'h1, 1'b0, 1'b0);
    for (int c = 0; c < 2; c++) begin
      reg_wr(0, c ? 64'h0000_ff2e_0000_0007 : 64'h0000_0010_0000_0007);
      for (int k = 0; k < 13; k++) begin
        step(xfer_kind_t'(k), pv[k % 3], 2'h3, 1'b0, 1'b0);
      end
    end
    reg_wr(0, 64'h81);
    step(XF_DIRCALL, 2'h0, 2'h3, 1'b0, 1'b0);
    step(XF_TKBR, 2'h0, 2'h3, 1'b0, 1'b0);
    step(XF_INDCALL, 2'h0, 2'h3, 1'b0, 1'b0);
    step(XF_RET, 2'h0, 2'h3, 1'b0, 1'b0);
    step(XF_RET, 2'h0, 2'h3, 1'b0, 1'b0);
    reg_wr(0, 64'h801);
    step(XF_EXC, 2'h0, 2'h3, 1'b1, 1'b0);
    step(XF_TKBR, 2'h0, 2'h3, 1'b0, 1'b0);
    reg_wr(3, 64'h0);
    check("halt cleared", recorder_halted_flag_out, 64'h0);
    reg_wr(0, 64'h1001);
    step(XF_INTR, 2'h0, 2'h1, 1'b0, 1'b1);
    reg_wr(3, 64'h0);
    for (int i = 0; i < 48; i++) begin
      if (i % 8 == 0) begin
        reg_wr(0, {$urandom, $urandom} & ~64'h80);
      end
      step(xfer_kind_t'($urandom % 13), pv[$urandom % 3], ($urandom % 2) ? 2'h3 : 2'h1, 1'b0, 1'b0);
    end
    end_sim();
  end
endmodule
